// ==== rtl/ptb_timebase.sv ====
// pwm time base with configuration register and interrupt logic
// assumes synchronous inputs on CLK_SYS_IN; fosc/4 equals CLK_SYS_IN
`timescale 1ns/1ps
`include "ptb_consts.svh"
// Operation
// - postscale field bits 7..4 code n gives an event ratio of 1:(n+1).
// - prescale code 00 counts on every base clock (1:1).
// - prescale code 01 counts every 4th base clock.
// - prescale code 10 counts every 16th base clock.
// - prescale code 11 counts every 64th base clock.
// - mode 11 counts up and down and interrupts at both zero and period.
// - mode 10 counts up and down and interrupts at zero only.
// - mode 01 runs one period, then stops and clears run enable.
// - free-running mode gives edge-aligned timing (up count only).
// - both up/down modes give center-aligned timing.
// - the counter advances only while run enable is set.
module ptb_timebase import ptb_pkg::*; #(
	parameter int CNT_W = 12
) (
	input  wire logic             CLK_SYS_IN,
	input  wire logic             RST_IN,
	input  wire logic [3:0]       AVS_ADDRESS_IN,
	input  wire logic             AVS_READ_IN,
	input  wire logic             AVS_WRITE_IN,
	input  wire logic [31:0]      AVS_WRITEDATA_IN,
	output logic      [31:0]      AVS_READDATA_OUT,
	output logic                  AVS_WAITREQUEST_OUT,
	output logic      [CNT_W-1:0] TB_COUNT_OUT,
	output logic                  TB_DIR_DOWN_OUT,
	output logic                  TB_EVENT_OUT,
	output logic                  IRQ_OUT
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	// period lives in control2 bits 16 and up, so 16 bits at most
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
		$error("CNT_W out of range");
	end

	// ----------------------------------------
	// timing constants
	// ----------------------------------------
	localparam logic [7:0] PRE_DIV1  = `PTB_PRE_DIV1;
	localparam logic [7:0] PRE_DIV4  = `PTB_PRE_DIV4;
	localparam logic [7:0] PRE_DIV16 = `PTB_PRE_DIV16;
	localparam logic [7:0] PRE_DIV64 = `PTB_PRE_DIV64;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	ptb_cfg_t         cfg_r;
	logic             run_r;
	logic [CNT_W-1:0] period_r;
	logic [2:0]       stat_r;
	logic [2:0]       mask_r;
	logic             ack_r;
	logic [31:0]      rd_r;
	logic             irq_r;

	// ----------------------------------------
	// counting state
	// ----------------------------------------
	logic [7:0]       pre_cnt_r;
	logic [3:0]       post_cnt_r;
	logic [CNT_W-1:0] cnt_r;
	logic             down_r;
	logic             evt_r;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// one wait state: taken while ack_r is low, completed at the
	// next edge; writes commit only at that completing edge
	wire              any_req  = AVS_READ_IN | AVS_WRITE_IN;
	wire              take     = any_req & ~ack_r;
	wire              wr       = AVS_WRITE_IN & ack_r;
	wire              ack_nxt  = take;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire              sel_cfg  = AVS_ADDRESS_IN == `PTB_OFF_CONFIG;
	wire              sel_ctl  = AVS_ADDRESS_IN == `PTB_OFF_CONTROL2;
	wire              sel_st   = AVS_ADDRESS_IN == `PTB_OFF_STATUS;
	wire              sel_msk  = AVS_ADDRESS_IN == `PTB_OFF_MASK;
	wire              wr_cfg   = wr & sel_cfg;
	wire              wr_ctl   = wr & sel_ctl;
	wire              wr_st    = wr & sel_st;
	wire              wr_msk   = wr & sel_msk;

	// ----------------------------------------
	// write data fields
	// ----------------------------------------
	wire [7:0]        wd_cfg   = AVS_WRITEDATA_IN[7:0];
	wire              wd_run   = AVS_WRITEDATA_IN[`PTB_RUN_BIT];
	wire [CNT_W-1:0]  wd_per   = AVS_WRITEDATA_IN[16 +: CNT_W];
	wire [2:0]        wd_bits  = AVS_WRITEDATA_IN[2:0];

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [15:0]       per_hi   = 16'(period_r);
	wire [31:0]       rd_cfg   = {24'h000000, cfg_r};
	wire [31:0]       rd_ctl   = {per_hi, 15'h0000, run_r};
	wire [31:0]       rd_st    = {29'h00000000, stat_r};
	wire [31:0]       rd_msk   = {29'h00000000, mask_r};
	// unmapped offsets read zero
	wire [31:0]       rd_mux   =
		sel_cfg ? rd_cfg :
		sel_ctl ? rd_ctl :
		sel_st  ? rd_st  :
		sel_msk ? rd_msk : 32'h00000000;
	// captured at the taking edge, stands until the next access
	wire [31:0]       rd_nxt   = take ? rd_mux : rd_r;

	// ----------------------------------------
	// config fields
	// ----------------------------------------
	wire [3:0]        post_sel = cfg_r.post;
	wire [1:0]        pre_sel  = cfg_r.pre;
	ptb_mode_t        mode_sel;
	assign mode_sel = cfg_r.mode;
	wire              is_single = mode_sel == PTB_SINGLE;
	wire              is_updn   = mode_sel == PTB_UPDN;
	wire              is_dbl    = mode_sel == PTB_UPDN_DB;
	wire              updn      = is_updn | is_dbl;

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	// divider restarts while stopped, so a fresh run gets a full gap
	wire [7:0]        pre_max  =
		(pre_sel == 2'b00) ? PRE_DIV1  :
		(pre_sel == 2'b01) ? PRE_DIV4  :
		(pre_sel == 2'b10) ? PRE_DIV16 :
		                     PRE_DIV64;
	wire              pre_top  = pre_cnt_r >= pre_max;
	wire              tick     = run_r & pre_top;
	wire [7:0]        pre_inc  = pre_cnt_r + 8'h01;
	wire [7:0]        pre_nxt  = (!run_r || tick) ? 8'h00 : pre_inc;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// >= so a period lowered below the count still wraps at once
	wire              at_per   = cnt_r >= period_r;
	wire              at_zero  = cnt_r == '0;
	wire [CNT_W-1:0]  cnt_inc  = cnt_r + CNT_W'(1);
	wire [CNT_W-1:0]  cnt_dec  = cnt_r - CNT_W'(1);
	logic [CNT_W-1:0] cnt_nxt;
	logic             down_nxt;
	always_comb begin
		cnt_nxt  = cnt_r;
		// up-only modes never show a stale down flag
		down_nxt = updn ? down_r : 1'b0;
		if (tick) begin
			if (!updn) begin
				cnt_nxt = at_per ? '0 : cnt_inc;
			end else if (!down_r) begin
				down_nxt = at_per;
				cnt_nxt  = at_per ? cnt_dec : cnt_inc;
			end else begin
				down_nxt = !at_zero;
				cnt_nxt  = at_zero ? cnt_inc : cnt_dec;
			end
		end
	end

	// ----------------------------------------
	// events and postscaler
	// ----------------------------------------
	wire              wrap     = tick & at_per & ~updn;
	wire              hit_per  = tick & at_per & updn & ~down_r;
	wire              hit_zero = tick & at_zero & updn & down_r;
	wire              oneshot  = wrap & is_single;
	wire              per_evt  = hit_per & is_dbl;
	wire              base_evt = wrap | hit_zero | per_evt;
	wire              post_top = post_cnt_r >= post_sel;
	wire              post_hit = base_evt & post_top;
	wire [3:0]        post_inc = post_cnt_r + 4'h1;
	wire [3:0]        post_nxt = !base_evt ? post_cnt_r :
		(post_hit ? 4'h0 : post_inc);

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	logic [2:0]       ev_set;
	always_comb begin
		ev_set = 3'h0;
		ev_set[`PTB_ST_ZERO]    = post_hit;
		ev_set[`PTB_ST_PERIOD]  = per_evt & post_hit;
		ev_set[`PTB_ST_ONESHOT] = oneshot;
	end
	wire [2:0]        w1c      = wr_st ? wd_bits : 3'h0;
	// set wins over a same-cycle clear, so no event is lost
	wire [2:0]        stat_nxt = (stat_r & ~w1c) | ev_set;
	wire              irq_nxt  = |(stat_nxt & mask_r);

	// ----------------------------------------
	// control next values
	// ----------------------------------------
	// a software write beats the single-shot self-stop
	wire              run_nxt  = wr_ctl ? wd_run :
		(oneshot ? 1'b0 : run_r);
	ptb_cfg_t         cfg_nxt;
	assign cfg_nxt = wr_cfg ? ptb_cfg_t'(wd_cfg) : cfg_r;
	wire [CNT_W-1:0]  per_nxt  = wr_ctl ? wd_per : period_r;
	wire [2:0]        msk_nxt  = wr_msk ? wd_bits : mask_r;

	// ----------------------------------------
	// bus flops
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			ack_r <= 1'b0;
			rd_r  <= 32'h00000000;
		end else begin
			ack_r <= ack_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// ----------------------------------------
	// config flops
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			cfg_r    <= ptb_cfg_t'(`PTB_CONFIG_RESET);
			run_r    <= 1'b0;
			period_r <= '1;
			mask_r   <= 3'h0;
		end else begin
			cfg_r    <= cfg_nxt;
			run_r    <= run_nxt;
			period_r <= per_nxt;
			mask_r   <= msk_nxt;
		end
	end

	// ----------------------------------------
	// status flops
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			stat_r <= 3'h0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// ----------------------------------------
	// scaler flops
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			pre_cnt_r  <= 8'h00;
			post_cnt_r <= 4'h0;
		end else begin
			pre_cnt_r  <= pre_nxt;
			post_cnt_r <= post_nxt;
		end
	end

	// ----------------------------------------
	// counter flops
	// ----------------------------------------
	// count is kept, not cleared, when run enable drops
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			cnt_r  <= '0;
			down_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			down_r <= down_nxt;
		end
	end

	// ----------------------------------------
	// output flops
	// ----------------------------------------
	// event pulse rises in the same cycle as the status bit
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			evt_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			evt_r <= post_hit;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign AVS_READDATA_OUT    = rd_r;
	assign AVS_WAITREQUEST_OUT = ~ack_r;
	assign TB_COUNT_OUT        = cnt_r;
	assign TB_DIR_DOWN_OUT     = down_r;
	assign TB_EVENT_OUT        = evt_r;
	assign IRQ_OUT             = irq_r;

endmodule // ptb_timebase

// ==== shared/ptb_consts.svh ====
// constants for the pwm time base configuration block
// assumes 32-bit avalon-mm word addressing by byte offset
`ifndef PTB_CONSTS_SVH
`define PTB_CONSTS_SVH
`define PTB_OFF_CONFIG      4'h0
`define PTB_OFF_CONTROL2    4'h4
`define PTB_OFF_STATUS      4'h8
`define PTB_OFF_MASK        4'hc
`define PTB_CONFIG_RESET    8'h00
`define PTB_POST_MSB        7
`define PTB_POST_LSB        4
`define PTB_PRE_MSB         3
`define PTB_PRE_LSB         2
`define PTB_MODE_MSB        1
`define PTB_MODE_LSB        0
`define PTB_RUN_BIT         0
`define PTB_PRE_DIV1        8'h00
`define PTB_PRE_DIV4        8'h03
`define PTB_PRE_DIV16       8'h0f
`define PTB_PRE_DIV64       8'h3f
`define PTB_ST_ZERO         0
`define PTB_ST_PERIOD       1
`define PTB_ST_ONESHOT      2
`endif

// ==== shared/ptb_pkg.sv ====
// types for the pwm time base configuration block
// assumes ptb_consts.svh is included by users needing offsets
package ptb_pkg;
	typedef enum logic [1:0] {
		PTB_FREE    = 2'b00,
		PTB_SINGLE  = 2'b01,
		PTB_UPDN    = 2'b10,
		PTB_UPDN_DB = 2'b11
	} ptb_mode_t;
	typedef struct packed {
		logic [3:0] post;
		logic [1:0] pre;
		ptb_mode_t  mode;
	} ptb_cfg_t;
endpackage

// ==== verif/ptb_timebase_bench.sv ====
// time base bench
// assumes the checker binds itself
`timescale 1ns/1ps
`include "ptb_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t got %0h want %0h", $time, a, b); end end
module ptb_timebase_bench import ptb_pkg::*; ;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, q, rdata;
	logic [11:0] cnt, c0;
	logic        wt, ev, dn, irq;
	int          n_fail = 0, n_compared = 0, cyc = 0, k;
	ptb_timebase u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wt),
		.TB_COUNT_OUT(cnt), .TB_DIR_DOWN_OUT(dn), .TB_EVENT_OUT(ev),
		.IRQ_OUT(irq));
	initial forever #25 clk = ~clk;
	task automatic test_done;
		$display("fails %0d compares %0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			test_done;
		end
	end
	// holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input int d);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// stop first: period 3 keeps every count short
	task automatic go(input ptb_cfg_t c);
		bus(1'b1, `PTB_OFF_CONTROL2, 32'h0003_0000);
		bus(1'b1, `PTB_OFF_CONFIG, c);
		bus(1'b1, `PTB_OFF_STATUS, 32'h7);
		bus(1'b1, `PTB_OFF_CONTROL2, 32'h0003_0001);
	endtask
	task automatic edge_gap(input logic x);
		c0 = cnt;
		while (cnt === c0) @(posedge clk);
		for (k = 1, c0 = cnt; cnt === c0; k++) @(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, 4'h1, 0);
		`CHK(q, 32'h0)
		bus(1'b0, `PTB_OFF_CONTROL2, 0);
		`CHK(q, 32'h0fff_0000)
		for (int p = 0; p < 4; p++) begin
			go('{4'h0, p[1:0], PTB_FREE});
			edge_gap(1'b0);
			`CHK(k - 1, 1 << 2 * p)
		end
		for (int n = 0; n < 16; n += 15) begin
			go('{n[3:0], 2'h0, PTB_FREE});
			while (ev !== 1'b1) @(posedge clk);
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (ev !== 1'b1);
			`CHK(k, 4 * (n + 1))
		end
		bus(1'b1, `PTB_OFF_CONTROL2, 32'h0003_0000);
		c0 = cnt;
		repeat (4) @(posedge clk);
		`CHK(cnt, c0)
		bus(1'b0, `PTB_OFF_STATUS, 0);
		`CHK(q[2:0], 3'h1)
		`CHK(irq, 1'b0)
		bus(1'b1, `PTB_OFF_MASK, 1);
		@(posedge clk);
		`CHK(irq, 1'b1)
		bus(1'b1, `PTB_OFF_STATUS, 1);
		@(posedge clk);
		`CHK(irq, 1'b0)
		go('{4'h0, 2'h0, PTB_SINGLE});
		repeat (12) @(posedge clk);
		`CHK(cnt, 12'h0)
		bus(1'b0, `PTB_OFF_STATUS, 0);
		`CHK(q[2], 1'b1)
		for (int m = 2; m < 4; m++) begin
			go('{4'h0, 2'h0, ptb_mode_t'(m)});
			repeat (20) @(posedge clk);
			bus(1'b0, `PTB_OFF_STATUS, 0);
			`CHK(q[1], m[0])
		end
		test_done;
	end
endmodule // ptb_timebase_bench

// ==== verif/ptb_timebase_sva.sv ====
// time base port checker
// assumes only software writes change config
`timescale 1ns/1ps
module ptb_timebase_sva #(parameter int CNT_W = 12) (
	input wire logic             CLK_SYS_IN,
	input wire logic             RST_IN,
	input wire logic [3:0]       AVS_ADDRESS_IN,
	input wire logic             AVS_WRITE_IN,
	input wire logic [31:0]      AVS_WRITEDATA_IN,
	input wire logic             AVS_WAITREQUEST_OUT,
	input wire logic [CNT_W-1:0] TB_COUNT_OUT,
	input wire logic             TB_DIR_DOWN_OUT
);
	logic [7:0]       cfg_r;
	logic [CNT_W-1:0] per_r;
	logic             run_r;
	wire              wok = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
	wire              f0 = run_r && cfg_r[3:0] == 4'h0;
	// run seen from writes only; single-shot self-stop is missed
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			cfg_r <= 8'h00;
			per_r <= '1;
			run_r <= 1'b0;
		end else if (wok && AVS_ADDRESS_IN == 4'h0) begin
			cfg_r <= AVS_WRITEDATA_IN[7:0];
		end else if (wok && AVS_ADDRESS_IN == 4'h4) begin
			per_r <= AVS_WRITEDATA_IN[16 +: CNT_W];
			run_r <= AVS_WRITEDATA_IN[0];
		end
	end
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);
	a_stop_holds: assert property (!run_r |=> $stable(TB_COUNT_OUT))
		else $error("count moved");
	a_free_step: assert property (f0 && TB_COUNT_OUT != per_r
		|=> TB_COUNT_OUT == $past(TB_COUNT_OUT) + 1'b1) else $error("step");
	a_free_wrap: assert property (f0 && TB_COUNT_OUT == per_r
		|=> TB_COUNT_OUT == '0) else $error("wrap");
	a_free_up: assert property (run_r && cfg_r[1:0] == 2'h0
		|=> !TB_DIR_DOWN_OUT) else $error("down");
	a_down_step: assert property (run_r && cfg_r[3:1] == 3'h1
		&& TB_DIR_DOWN_OUT && TB_COUNT_OUT != '0
		|=> TB_COUNT_OUT == $past(TB_COUNT_OUT) - 1'b1) else $error("dec");
	a_single_stop: assert property (cfg_r[1:0] == 2'h1
		&& TB_COUNT_OUT == '0 && $past(TB_COUNT_OUT) != '0
		|-> (TB_COUNT_OUT == '0)[*4]) else $error("single");
	a_pre_four: assert property (run_r && cfg_r[3:2] == 2'h1
		&& $changed(TB_COUNT_OUT) |=> $stable(TB_COUNT_OUT)[*3])
		else $error("pre4");
	a_pre_top: assert property (run_r && cfg_r[3:2] == 2'h3
		&& $changed(TB_COUNT_OUT) |=> $stable(TB_COUNT_OUT)[*8])
		else $error("pre64");
	c_wrap: cover property (f0 && TB_COUNT_OUT == per_r);
	c_down: cover property (run_r && TB_DIR_DOWN_OUT);
	c_slow: cover property (run_r && cfg_r[3:2] == 2'h3);
endmodule // ptb_timebase_sva
bind ptb_timebase ptb_timebase_sva #(.CNT_W(CNT_W)) u_sva (
	.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
	.AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.TB_COUNT_OUT(TB_COUNT_OUT), .TB_DIR_DOWN_OUT(TB_DIR_DOWN_OUT));
